// ==== rtl/edaux_pkg.sv ====
package edaux_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [4:0] ADR_CTRL = 5'h00;
   localparam logic [4:0] ADR_WIN = 5'h04;
   localparam logic [4:0] ADR_DIV = 5'h08;
   localparam logic [4:0] ADR_MARK = 5'h0c;
   localparam logic [4:0] ADR_PLEN = 5'h10;
   localparam logic [4:0] ADR_BLKROW = 5'h14;
   localparam logic [4:0] ADR_STAT = 5'h18;
   // ----------------------------------------
   // Control and BLKROW field positions
   // ----------------------------------------
   localparam int unsigned CTRL_BURST = 0;
   localparam int unsigned CTRL_INFN_LO = 1;
   localparam int unsigned CTRL_CAPEXT = 3;
   localparam int unsigned CTRL_OSEL_LO = 4;
   localparam int unsigned CTRL_DUAL = 6;
   localparam int unsigned CTRL_MIXED = 7;
   localparam int unsigned BLKROW_ROW_LO = 16;
   // ----------------------------------------
   // Reset values and write limits
   // ----------------------------------------
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] WIN_MIN_1 = 32'd12800;
   localparam logic [31:0] WIN_MAX_1 = 32'd2147483392;
   localparam logic [31:0] WIN_MIN_2 = 32'd25600;
   localparam logic [31:0] WIN_MAX_2 = 32'd4294966784;
   localparam int unsigned WIN_STEP_SH_1 = 8;
   localparam int unsigned WIN_STEP_SH_2 = 9;
   localparam logic [9:0] DIV_MIN = 10'd4;
   localparam logic [9:0] DIV_MAX = 10'd512;
   localparam logic [31:0] PLEN_RST = 32'd512;
   // ----------------------------------------
   // Pattern length and marker limits
   // ----------------------------------------
   localparam logic [31:0] PLEN_MIN_1 = 32'd512;
   localparam logic [31:0] PLEN_MIN_2 = 32'd1024;
   localparam logic [38:0] MARK_OFS_1 = 39'd135;
   localparam logic [38:0] MARK_OFS_2 = 39'd271;
   localparam int unsigned MARK_STEP_SH_1 = 3;
   localparam int unsigned MARK_STEP_SH_2 = 4;
   localparam logic [3:0] LCM_BASE_SH = 4'd7;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      IN_TRIG = 2'h0,
      IN_ENA = 2'h1,
      IN_MASK = 2'h2,
      IN_CAP = 2'h3
   } edaux_in_fn_t;
   typedef enum logic [1:0] {
      OUT_DIV = 2'h0,
      OUT_MARK = 2'h1,
      OUT_SYNC = 2'h2,
      OUT_ERR = 2'h3
   } edaux_out_t;
   typedef enum logic [1:0] {
      CALC_IDLE = 2'b01,
      CALC_RUN = 2'b10
   } edaux_calc_t;
endpackage

// ==== rtl/edaux_in_if.sv ====
`timescale 1ns/1ps
interface edaux_in_if;
   logic lvl;
   logic rise;
   modport src (output lvl, output rise);
   modport dst (input lvl, input rise);
endinterface

// ==== rtl/edaux_in_cond.sv ====
`timescale 1ns/1ps
module edaux_in_cond (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic i_aux_in,
   edaux_in_if.src aux
);
   logic s1;
   logic s2;
   logic s3;

   // ----------------------------------------
   // Synchroniser and edge detect
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else if (i_clk_en) begin
         s1 <= i_aux_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   assign aux.lvl = s2;
   assign aux.rise = s2 & ~s3;
endmodule

// ==== rtl/edaux_top.sv ====
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
// Overview of operation
// - With trigger gating, data is valid for the window length after a rising aux edge.
// - With level gating, data is valid only while the aux input is high.
// - In mask mode, measurement is suspended while the aux input is low.
// - With external capture trigger, a capture starts on the aux rising edge.
// - The divided clock runs at one N-th of the bit rate, N even from 4 to 512, pattern aligned.
// - One marker per pattern period at a position 1 to lcm(length,128)-135 in 8-bit steps.
// - With dual channels the limit is lcm(length,128)-271 in 16-bit steps.
// - Short patterns are repeated to at least 512 bits, or 1024 with dual channels.
// - Mixed patterns place the marker by block index and row index.
// - The sync output is high while pattern sync is held.
// - The error output is high when a bit error is detected.
// - Window length is clamped on write to 12800 to 2147483392 bits in 256-bit steps, or 25600 to 4294966784 in 512-bit steps with dual channels.
module edaux_top #(
   parameter int unsigned BLK_W = 8,
   parameter int unsigned ROW_W = 8
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_aux_in,
   input wire logic i_pat_start,
   input wire logic i_row_start,
   input wire logic [BLK_W-1:0] i_blk_idx,
   input wire logic [ROW_W-1:0] i_row_idx,
   input wire logic i_sync_ok,
   input wire logic i_bit_err,
   output logic o_aux_out,
   output logic o_data_valid,
   output logic o_meas_enable,
   output logic o_capture_start
);
   logic [31:0] ctrl;
   logic [31:0] win_len;
   logic [9:0] div_n;
   logic [31:0] mark_k;
   logic [31:0] plen;
   logic [31:0] plen_eff;
   logic [31:0] acc;
   logic [BLK_W-1:0] cfg_blk;
   logic [ROW_W-1:0] cfg_row;
   edaux_pkg::edaux_calc_t calc_st;
   logic [31:0] win_cnt;
   logic [8:0] dcnt;
   logic div_clk;
   logic [38:0] bit_pos;
   logic [31:0] rd_mux;
   logic [31:0] wr_val;
   logic wr_hit;
   logic dual;
   logic mixed;
   logic burst;
   logic busy;
   edaux_pkg::edaux_in_fn_t in_fn;
   edaux_pkg::edaux_out_t out_sel;
   logic [3:0] lcm_sh;
   logic [38:0] lcm;
   logic [38:0] kmax;
   logic [38:0] k_eff;
   logic [38:0] mark_pos;
   logic [38:0] cur_pos;
   logic mark_hit;
   logic [8:0] half;
   logic [31:0] win_min;
   logic [31:0] win_max;

   edaux_in_if aux ();

   edaux_in_cond u_in_cond (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_clk_en(i_clk_en),
      .i_aux_in(i_aux_in),
      .aux(aux)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] f_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [3:0] f_tz(input logic [6:0] v);
      logic [3:0] t;
      t = edaux_pkg::LCM_BASE_SH;
      for (int i = 6; i >= 0; i--) begin
         if (v[i]) begin
            t = 4'(i);
         end
      end
      return t;
   endfunction

   assign dual = ctrl[edaux_pkg::CTRL_DUAL];
   assign mixed = ctrl[edaux_pkg::CTRL_MIXED];
   assign burst = ctrl[edaux_pkg::CTRL_BURST];
   assign in_fn = edaux_pkg::edaux_in_fn_t'(ctrl[edaux_pkg::CTRL_INFN_LO +: 2]);
   assign out_sel = edaux_pkg::edaux_out_t'(ctrl[edaux_pkg::CTRL_OSEL_LO +: 2]);
   assign busy = (calc_st == edaux_pkg::CALC_RUN);
   assign wr_hit = i_clk_en & i_avs_write & ~o_avs_waitrequest;
   assign wr_val = f_merge(rd_mux, i_avs_writedata, i_avs_byteenable);
   assign win_min = dual ? edaux_pkg::WIN_MIN_2 : edaux_pkg::WIN_MIN_1;
   assign win_max = dual ? edaux_pkg::WIN_MAX_2 : edaux_pkg::WIN_MAX_1;

   // ----------------------------------------
   // Avalon slave
   // ----------------------------------------
   always_comb begin
      rd_mux = 32'h0;
      case (i_avs_address)
         edaux_pkg::ADR_CTRL: rd_mux = ctrl;
         edaux_pkg::ADR_WIN: rd_mux = win_len;
         edaux_pkg::ADR_DIV: rd_mux = {22'h0, div_n};
         edaux_pkg::ADR_MARK: rd_mux = mark_k;
         edaux_pkg::ADR_PLEN: rd_mux = plen;
         edaux_pkg::ADR_BLKROW: begin
            rd_mux[BLK_W-1:0] = cfg_blk;
            rd_mux[edaux_pkg::BLKROW_ROW_LO +: ROW_W] = cfg_row;
         end
         edaux_pkg::ADR_STAT: rd_mux = {26'h0, busy, win_cnt != 32'h0, o_data_valid,
                                        aux.lvl, i_sync_ok, i_bit_err};
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h0;
      end else if (i_clk_en) begin
         if (o_avs_waitrequest && (i_avs_read || i_avs_write)) begin
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata <= i_avs_read ? rd_mux : 32'h0;
         end else begin
            o_avs_waitrequest <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         ctrl <= edaux_pkg::CTRL_RST;
         win_len <= edaux_pkg::WIN_MIN_1;
         div_n <= edaux_pkg::DIV_MIN;
         mark_k <= 32'h0;
         cfg_blk <= '0;
         cfg_row <= '0;
      end else if (wr_hit) begin
         unique case (i_avs_address)
            edaux_pkg::ADR_CTRL: ctrl <= {24'h0, wr_val[7:0]};
            edaux_pkg::ADR_WIN: begin
               if (wr_val < win_min) begin
                  win_len <= win_min;
               end else if (wr_val > win_max) begin
                  win_len <= win_max;
               end else if (dual) begin
                  win_len <= (wr_val >> edaux_pkg::WIN_STEP_SH_2) << edaux_pkg::WIN_STEP_SH_2;
               end else begin
                  win_len <= (wr_val >> edaux_pkg::WIN_STEP_SH_1) << edaux_pkg::WIN_STEP_SH_1;
               end
            end
            edaux_pkg::ADR_DIV: begin
               if (wr_val < 32'(edaux_pkg::DIV_MIN)) begin
                  div_n <= edaux_pkg::DIV_MIN;
               end else if (wr_val > 32'(edaux_pkg::DIV_MAX)) begin
                  div_n <= edaux_pkg::DIV_MAX;
               end else begin
                  div_n <= {wr_val[9:1], 1'b0};
               end
            end
            edaux_pkg::ADR_MARK: mark_k <= wr_val;
            edaux_pkg::ADR_BLKROW: begin
               cfg_blk <= wr_val[BLK_W-1:0];
               cfg_row <= wr_val[edaux_pkg::BLKROW_ROW_LO +: ROW_W];
            end
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Effective pattern length
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         plen <= edaux_pkg::PLEN_RST;
         plen_eff <= edaux_pkg::PLEN_RST;
         acc <= edaux_pkg::PLEN_RST;
         calc_st <= edaux_pkg::CALC_IDLE;
      end else if (i_clk_en) begin
         if (wr_hit && i_avs_address == edaux_pkg::ADR_PLEN) begin
            plen <= (wr_val == 32'h0) ? 32'h1 : wr_val;
            acc <= (wr_val == 32'h0) ? 32'h1 : wr_val;
            calc_st <= edaux_pkg::CALC_RUN;
         end else if (wr_hit && i_avs_address == edaux_pkg::ADR_CTRL) begin
            acc <= plen;
            calc_st <= edaux_pkg::CALC_RUN;
         end else begin
            unique case (calc_st)
               edaux_pkg::CALC_IDLE: ;
               edaux_pkg::CALC_RUN: begin
                  if (acc >= (dual ? edaux_pkg::PLEN_MIN_2 : edaux_pkg::PLEN_MIN_1)) begin
                     plen_eff <= acc;
                     calc_st <= edaux_pkg::CALC_IDLE;
                  end else begin
                     acc <= acc + plen;
                  end
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // Marker position
   // ----------------------------------------
   assign lcm_sh = edaux_pkg::LCM_BASE_SH - f_tz(plen_eff[6:0]);
   assign lcm = {7'h0, plen_eff} << lcm_sh;
   assign kmax = dual ? ((lcm - edaux_pkg::MARK_OFS_2 - 39'd1) >> edaux_pkg::MARK_STEP_SH_2)
                      : ((lcm - edaux_pkg::MARK_OFS_1 - 39'd1) >> edaux_pkg::MARK_STEP_SH_1);
   assign k_eff = ({7'h0, mark_k} > kmax) ? kmax : {7'h0, mark_k};
   assign mark_pos = dual ? (39'd1 + (k_eff << edaux_pkg::MARK_STEP_SH_2))
                          : (39'd1 + (k_eff << edaux_pkg::MARK_STEP_SH_1));
   assign cur_pos = i_pat_start ? 39'd1 : bit_pos;
   assign mark_hit = mixed ? (i_row_start && i_blk_idx == cfg_blk && i_row_idx == cfg_row)
                           : (!busy && cur_pos == mark_pos);

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         bit_pos <= 39'd1;
      end else if (i_clk_en) begin
         bit_pos <= (cur_pos >= lcm) ? 39'd1 : cur_pos + 39'd1;
      end
   end

   // ----------------------------------------
   // Divided clock
   // ----------------------------------------
   assign half = div_n[9:1];

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         dcnt <= 9'd1;
         div_clk <= 1'b0;
      end else if (i_clk_en) begin
         if (i_pat_start) begin
            dcnt <= 9'd1;
            div_clk <= 1'b1;
         end else if (wr_hit && i_avs_address == edaux_pkg::ADR_DIV) begin
            dcnt <= 9'd1;
         end else if (dcnt >= half) begin
            dcnt <= 9'd1;
            div_clk <= ~div_clk;
         end else begin
            dcnt <= dcnt + 9'd1;
         end
      end
   end

   // ----------------------------------------
   // Aux input functions
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         win_cnt <= 32'h0;
      end else if (i_clk_en) begin
         if (burst && in_fn == edaux_pkg::IN_TRIG && aux.rise) begin
            win_cnt <= win_len;
         end else if (win_cnt != 32'h0) begin
            win_cnt <= win_cnt - 32'h1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_data_valid <= 1'b0;
         o_meas_enable <= 1'b0;
         o_capture_start <= 1'b0;
      end else if (i_clk_en) begin
         if (!burst || in_fn == edaux_pkg::IN_MASK || in_fn == edaux_pkg::IN_CAP) begin
            o_data_valid <= 1'b1;
         end else if (in_fn == edaux_pkg::IN_ENA) begin
            o_data_valid <= aux.lvl;
         end else begin
            o_data_valid <= (win_cnt != 32'h0);
         end
         o_meas_enable <= !(in_fn == edaux_pkg::IN_MASK && !aux.lvl);
         o_capture_start <= ctrl[edaux_pkg::CTRL_CAPEXT] && in_fn == edaux_pkg::IN_CAP
                            && aux.rise;
      end
   end

   // ----------------------------------------
   // Aux output select
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_aux_out <= 1'b0;
      end else if (i_clk_en) begin
         unique case (out_sel)
            edaux_pkg::OUT_DIV: o_aux_out <= div_clk;
            edaux_pkg::OUT_MARK: o_aux_out <= mark_hit;
            edaux_pkg::OUT_SYNC: o_aux_out <= i_sync_ok;
            edaux_pkg::OUT_ERR: o_aux_out <= i_bit_err;
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_win_start;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_clk_en && burst && in_fn == edaux_pkg::IN_TRIG && aux.rise) |=> (win_cnt == $past(win_len));
   endproperty
   a_win_start: assert property (p_win_start) else $error("window not loaded on edge");

   property p_lvl_valid;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_clk_en && burst && in_fn == edaux_pkg::IN_ENA) |=> (o_data_valid == $past(aux.lvl));
   endproperty
   a_lvl_valid: assert property (p_lvl_valid) else $error("level gate mismatch");

   property p_mask;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_clk_en && in_fn == edaux_pkg::IN_MASK && !aux.lvl) |=> !o_meas_enable;
   endproperty
   a_mask: assert property (p_mask) else $error("measure not masked");

   property p_cap;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_clk_en && ctrl[edaux_pkg::CTRL_CAPEXT] && in_fn == edaux_pkg::IN_CAP && aux.rise)
      |=> o_capture_start ##1 (!i_clk_en || !o_capture_start);
   endproperty
   a_cap: assert property (p_cap) else $error("capture start wrong");

   property p_div_range;
      @(posedge i_clk) disable iff (i_sys_rst)
      (div_n >= edaux_pkg::DIV_MIN && div_n <= edaux_pkg::DIV_MAX && !div_n[0]
       && dcnt <= half);
   endproperty
   a_div_range: assert property (p_div_range) else $error("divider out of range");

   property p_mark_lim;
      @(posedge i_clk) disable iff (i_sys_rst)
      !busy |-> (mark_pos + (dual ? edaux_pkg::MARK_OFS_2 : edaux_pkg::MARK_OFS_1) <= lcm);
   endproperty
   a_mark_lim: assert property (p_mark_lim) else $error("marker past limit");

   property p_plen_eff;
      @(posedge i_clk) disable iff (i_sys_rst)
      !busy |-> (plen_eff >= (dual ? edaux_pkg::PLEN_MIN_2 : edaux_pkg::PLEN_MIN_1)
                 || $past(wr_hit));
   endproperty
   a_plen_eff: assert property (p_plen_eff) else $error("pattern length short");

   property p_mark_out;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_clk_en && out_sel == edaux_pkg::OUT_MARK && !mixed && !busy && cur_pos == mark_pos)
      |=> o_aux_out;
   endproperty
   a_mark_out: assert property (p_mark_out) else $error("marker pulse missing");

   property p_sync_out;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_clk_en && out_sel == edaux_pkg::OUT_SYNC) |=> (o_aux_out == $past(i_sync_ok));
   endproperty
   a_sync_out: assert property (p_sync_out) else $error("sync output wrong");

   property p_err_out;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_clk_en && out_sel == edaux_pkg::OUT_ERR) |=> (o_aux_out == $past(i_bit_err));
   endproperty
   a_err_out: assert property (p_err_out) else $error("error output wrong");

   property p_win_len;
      @(posedge i_clk) disable iff (i_sys_rst)
      (win_len >= edaux_pkg::WIN_MIN_1 && win_len[7:0] == 8'h0);
   endproperty
   a_win_len: assert property (p_win_len) else $error("window length illegal");
endmodule

// ==== tb/edaux_gate_src.sv ====
`timescale 1ns/1ps
module edaux_gate_src #(
   parameter int unsigned GAP = 512
) (
   input wire logic i_clk,
   output logic o_aux
);
   // ----------------
   // Gate drive
   // ----------------
   initial o_aux = 1'b0;
   task automatic set_level(input logic v);
      @(posedge i_clk);
      o_aux <= v;
   endtask
   task automatic pulse(input int w);
      set_level(1'b1);
      repeat (w) @(posedge i_clk);
      o_aux <= 1'b0;
      repeat (GAP) @(posedge i_clk);
   endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
   logic i_clk, i_sys_rst, i_avs_read, i_avs_write, i_pat_start, i_row_start;
   logic i_sync_ok, i_bit_err, o_avs_waitrequest, aux, o_aux_out;
   logic o_data_valid, o_meas_enable, o_capture_start, p, i_clk_en;
   logic [4:0] i_avs_address;
   logic [3:0] i_avs_byteenable;
   logic [31:0] i_avs_writedata, o_avs_readdata, rd;
   logic [7:0] i_blk_idx, i_row_idx;
   int errors, checks_done, cyc, n;
   // ----------------
   // Design and gate source
   // ----------------
   edaux_top i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
      .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
      .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_aux_in(aux),
      .i_pat_start(i_pat_start), .i_row_start(i_row_start),
      .i_blk_idx(i_blk_idx), .i_row_idx(i_row_idx), .i_sync_ok(i_sync_ok),
      .i_bit_err(i_bit_err), .o_aux_out(o_aux_out), .o_data_valid(o_data_valid),
      .o_meas_enable(o_meas_enable), .o_capture_start(o_capture_start));
   edaux_gate_src i_gate (.i_clk(i_clk), .o_aux(aux));
   // ----------------
   // Clock, timeout, reporting
   // ----------------
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         errors++;
         conclude();
      end
   end
   task conclude;
      if (errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask
   // ----------------
   // Bus access
   // ----------------
   task wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= 1'b1;
      do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
      i_avs_write <= 1'b0;
   endtask
   task rdr(input logic [4:0] a);
      @(posedge i_clk);
      i_avs_address <= a;
      i_avs_read <= 1'b1;
      do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
      rd = o_avs_readdata;
      i_avs_read <= 1'b0;
   endtask
   task rdc(input string s, input logic [4:0] a, input logic [31:0] e);
      rdr(a);
      chk(s, rd, e);
   endtask
   task idle;
      repeat (2000) begin
         rdr(edaux_pkg::ADR_STAT);
         if (rd[5] === 1'b0) break;
      end
   endtask
   // ----------------
   // Scenario helpers
   // ----------------
   task count(input int len, input bit cap);
      repeat (2) @(posedge i_clk);
      n = 0;
      fork
         i_gate.pulse(4);
         repeat (len) begin
            @(posedge i_clk);
            if ((cap ? o_capture_start : o_data_valid) === 1'b1) n++;
         end
      join
   endtask
   task mark(input logic [31:0] c, input logic [31:0] k, input bit row, input int e);
      wr(edaux_pkg::ADR_CTRL, c);
      idle();
      wr(edaux_pkg::ADR_MARK, k);
      idle();
      @(posedge i_clk);
      i_pat_start <= !row;
      i_row_start <= row;
      @(posedge i_clk);
      i_pat_start <= 1'b0;
      i_row_start <= 1'b0;
      n = 1;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_aux_out !== 1'b1 && n < 900);
      chk("marker position", 32'(n), 32'(e + 1));
   endtask
   // ----------------
   // Main sequence
   // ----------------
   initial begin
      {i_avs_read, i_avs_write, i_pat_start, i_row_start, i_sync_ok, i_bit_err} = '0;
      i_avs_address = '0;
      i_avs_writedata = '0;
      i_avs_byteenable = 4'hf;
      i_clk_en = 1'b1;
      i_blk_idx = '0;
      i_row_idx = '0;
      errors = 0;
      checks_done = 0;
      cyc = 0;
      i_sys_rst = 1'b1;
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rdc("ctrl", edaux_pkg::ADR_CTRL, 32'h0000_0000);
      rdc("win", edaux_pkg::ADR_WIN, 32'd12800);
      rdc("div", edaux_pkg::ADR_DIV, 32'd4);
      rdc("plen", edaux_pkg::ADR_PLEN, 32'd512);
      wr(5'h1c, 32'hffff_ffff);
      rdc("unmapped", 5'h1c, 32'h0000_0000);
      i_avs_byteenable <= 4'h2;
      wr(edaux_pkg::ADR_MARK, 32'hffff_ffff);
      i_avs_byteenable <= 4'hf;
      rdc("byte lanes", edaux_pkg::ADR_MARK, 32'h0000_ff00);
      wr(edaux_pkg::ADR_DIV, 32'd5);
      rdc("div odd", edaux_pkg::ADR_DIV, 32'd4);
      wr(edaux_pkg::ADR_DIV, 32'd1000);
      rdc("div max", edaux_pkg::ADR_DIV, 32'd512);
      wr(edaux_pkg::ADR_DIV, 32'd6);
      @(posedge i_clk);
      i_pat_start <= 1'b1;
      @(posedge i_clk);
      i_pat_start <= 1'b0;
      repeat (4) @(posedge i_clk);
      n = 0;
      p = o_aux_out;
      repeat (24) begin
         @(posedge i_clk);
         if (o_aux_out === 1'b1 && p === 1'b0) n++;
         p = o_aux_out;
      end
      chk("div rises", 32'(n), 32'd4);
      for (int o = 2; o < 4; o++) begin
         wr(edaux_pkg::ADR_CTRL, 32'(o << 4));
         for (int s = 0; s < 4; s++) begin
            @(posedge i_clk);
            i_sync_ok <= s[0];
            i_bit_err <= s[1];
            repeat (3) @(posedge i_clk);
            chk("aux out", {31'h0, o_aux_out}, (o == 2) ? s[0] : s[1]);
         end
      end
      i_clk_en <= 1'b0;
      i_bit_err <= 1'b0;
      repeat (3) @(posedge i_clk);
      chk("frozen out", {31'h0, o_aux_out}, 32'h1);
      i_clk_en <= 1'b1;
      repeat (3) @(posedge i_clk);
      chk("thawed out", {31'h0, o_aux_out}, 32'h0);
      wr(edaux_pkg::ADR_CTRL, 32'h03);
      i_gate.set_level(1'b1);
      repeat (4) @(posedge i_clk);
      chk("enable high", {31'h0, o_data_valid}, 32'h1);
      i_gate.set_level(1'b0);
      repeat (4) @(posedge i_clk);
      chk("enable low", {31'h0, o_data_valid}, 32'h0);
      wr(edaux_pkg::ADR_CTRL, 32'h04);
      repeat (2) @(posedge i_clk);
      chk("mask low", {31'h0, o_meas_enable}, 32'h0);
      i_gate.set_level(1'b1);
      repeat (4) @(posedge i_clk);
      chk("mask high", {31'h0, o_meas_enable}, 32'h1);
      i_gate.set_level(1'b0);
      wr(edaux_pkg::ADR_CTRL, 32'h0e);
      count(40, 1'b1);
      chk("capture ext", 32'(n), 32'd1);
      wr(edaux_pkg::ADR_CTRL, 32'h06);
      count(40, 1'b1);
      chk("capture int", 32'(n), 32'd0);
      wr(edaux_pkg::ADR_WIN, 32'd100);
      rdc("win min", edaux_pkg::ADR_WIN, 32'd12800);
      wr(edaux_pkg::ADR_WIN, 32'd13311);
      rdc("win step", edaux_pkg::ADR_WIN, 32'd13056);
      wr(edaux_pkg::ADR_CTRL, 32'h01);
      count(13600, 1'b0);
      chk("window bits", 32'(n), 32'd13056);
      mark(32'h10, 32'd2, 1'b0, 17);
      mark(32'h10, 32'd100, 1'b0, 377);
      mark(32'h50, 32'd2, 1'b0, 33);
      mark(32'h50, 32'd100, 1'b0, 753);
      wr(edaux_pkg::ADR_BLKROW, 32'h0005_0003);
      i_blk_idx <= 8'h03;
      i_row_idx <= 8'h05;
      mark(32'h90, 32'd0, 1'b1, 1);
      conclude();
   end
endmodule
